//--- design/gpr_bank_file.sv
// Purpose: banked general-purpose register file with peripheral window decode
// Assumes: cpu_req is synchronous and lasts one cycle per operation
// Notes: answers appear on cpu_rsp one edge after the request
//
// Operation
// - four banks of eight 4-bit registers
// - register area is data memory 00H-1FH
// - effective bank is enable AND choice
// - enable flag saved on call, restored on return
// - interrupt saves flag, loads vector setting
// - flag by set/clear, choice by select
// - 4-bit registers work against accumulator A
// - alternate pairs use bank bit 0 inverted
// - wide accumulator, pointer and auxiliary pointers
// - add-with-skip writes sum, skips on carry
// - peripherals decoded at F80H-FFFH
// - bit direct needs enable 0 or choice 15
// - special bit direct ignores data bank
// - bit indirect via pointer low ignores bank
// - 4-bit direct needs enable 0 or 15
// - 4-bit indirect needs enable 1, choice 15
// - 8-bit direct even, enable 0 or 15
// - 8-bit indirect needs 15 and even low
// - D-based pointers always address bank 0
// - choices readable singly or combined 8-bit; code reads them combined only
// - bank select accepts only banks 0-3
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps

module gpr_bank_file
   import gpr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // cpu execution side
   input wire gpr_req_t cpu_req,
   output gpr_rsp_t cpu_rsp
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [GPR_WORDS-1:0][3:0] regs;
      logic bank_window_enable;
      logic data_bank_enable;
      logic [3:0] bank_choice_register;
      logic [3:0] data_bank_choice;
      logic [STK_DEPTH-1:0] stk;
      logic [3:0] sp;
      logic [4:0] dbg_idx;
      logic wait_q;
      logic [31:0] rdata;
      gpr_rsp_t rsp;
   } gpr_state_t;

   gpr_state_t s_q;
   gpr_state_t s_d;

   assign avs_readdata = s_q.rdata;
   assign avs_waitrequest = s_q.wait_q;
   assign cpu_rsp = s_q.rsp;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [1:0] eb;
      logic [1:0] ab;
      logic [4:0] lo;
      logic [3:0] dbank;
      logic [3:0] hv;
      logic [3:0] lv;
      logic [3:0] dv;
      logic [3:0] ev;
      logic [11:0] addr;
      logic ok;
      logic wide;
      logic bad;
      logic inio;
      logic [4:0] ra;
      logic [8:0] sum;
      s_d = s_q;
      eb = s_q.bank_window_enable ? s_q.bank_choice_register[1:0] : 2'b00;
      ab = eb ^ {1'b0, cpu_req.alt};
      lo = {ab, cpu_req.reg_idx[2:1], 1'b0};
      // direct modes with the data bank disabled split the operand space: low half
      // reaches bank 0, high half the peripheral window
      dbank = s_q.data_bank_enable ? s_q.data_bank_choice : (cpu_req.operand[7] ? IO_BANK : 4'h0);
      hv = s_q.regs[{eb, OFF_H}];
      lv = s_q.regs[{eb, OFF_L}];
      dv = s_q.regs[{eb, OFF_D}];
      ev = s_q.regs[{eb, OFF_E}];
      addr = 12'h0000;
      ok = 1'b0;
      wide = 1'b0;
      bad = 1'b0;
      inio = 1'b0;
      ra = 5'h00;
      sum = 9'h000;

      // bus slave: one wait cycle, then answer
      s_d.wait_q = 1'b1;
      if ((avs_read || avs_write) && s_q.wait_q) begin
         s_d.wait_q = 1'b0;
         if (avs_read) begin
            unique case (avs_address)
               BUS_STATUS: s_d.rdata = {20'h0_0000, s_q.data_bank_choice, s_q.bank_choice_register, s_q.data_bank_enable, s_q.bank_window_enable, eb};
               BUS_INDEX: s_d.rdata = {27'h000_0000, s_q.dbg_idx};
               BUS_DATA: s_d.rdata = {28'h000_0000, s_q.regs[s_q.dbg_idx]};
               BUS_STACK: s_d.rdata = {20'h0_0000, s_q.stk, s_q.sp};
               default: s_d.rdata = 32'h0000_0000;
            endcase
         end
      end
      // a bus write lands only at the edge that sees waitrequest low
      if (avs_write && !s_q.wait_q) begin
         unique case (avs_address)
            BUS_INDEX: s_d.dbg_idx = avs_writedata[4:0];
            BUS_DATA: s_d.regs[s_q.dbg_idx] = avs_writedata[3:0];
            default: ;
         endcase
      end

      // cpu operations; a cpu write wins over a bus write
      s_d.rsp = '0;
      s_d.rsp.valid = (cpu_req.op != op_none);
      s_d.rsp.effective_bank = eb;
      unique case (cpu_req.op)
         op_none: ;
         // nibble registers of the effective bank
         op_rd4: s_d.rsp.rdata = {4'h0, s_q.regs[{eb, cpu_req.reg_idx}]};
         op_wr4: s_d.regs[{eb, cpu_req.reg_idx}] = cpu_req.wdata[3:0];
         op_xch4: begin
            // exchange with the 4-bit accumulator
            s_d.regs[{eb, cpu_req.reg_idx}] = s_q.regs[{eb, OFF_A}];
            s_d.regs[{eb, OFF_A}] = s_q.regs[{eb, cpu_req.reg_idx}];
            s_d.rsp.rdata = {4'h0, s_q.regs[{eb, cpu_req.reg_idx}]};
         end
         // pairs, alternate set from complementary bank
         op_rd8: s_d.rsp.rdata = {s_q.regs[lo | 5'h01], s_q.regs[lo]};
         op_wr8: begin
            s_d.regs[lo] = cpu_req.wdata[3:0];
            s_d.regs[lo | 5'h01] = cpu_req.wdata[7:4];
         end
         op_add_with_skip_instruction: begin
            // wide accumulator plus pair, skip on carry from bit 7
            sum = {1'b0, s_q.regs[{eb, OFF_X}], s_q.regs[{eb, OFF_A}]}
               + {1'b0, s_q.regs[lo | 5'h01], s_q.regs[lo]};
            s_d.regs[{eb, OFF_A}] = sum[3:0];
            s_d.regs[{eb, OFF_X}] = sum[7:4];
            s_d.rsp.rdata = sum[7:0];
            s_d.rsp.skip = sum[8];
         end
         // bank flags by their own instructions; enable flag also by interrupt entry and return
         op_set_rbe: s_d.bank_window_enable = 1'b1;
         op_clr_rbe: s_d.bank_window_enable = 1'b0;
         op_sel_rb: begin
            if (cpu_req.operand <= {4'h0, RBS_MAX}) begin
               s_d.bank_choice_register = cpu_req.operand[3:0];
            end else begin
               s_d.rsp.io_fault = 1'b1;
            end
         end
         op_set_mbe: s_d.data_bank_enable = 1'b1;
         op_clr_mbe: s_d.data_bank_enable = 1'b0;
         op_sel_mb: s_d.data_bank_choice = cpu_req.operand[3:0];
         // combined bank state, choice registers only
         op_rd_bs: s_d.rsp.rdata = {s_q.data_bank_choice, s_q.bank_choice_register};
         op_wr_bs: begin
            s_d.bank_choice_register = {2'b00, cpu_req.wdata[1:0]};
            s_d.data_bank_choice = cpu_req.wdata[7:4];
         end
         // save and restore the enable flag
         op_call, op_irq_entry: begin
            if (s_q.sp != STK_FULL) begin
               s_d.stk[s_q.sp[2:0]] = s_q.bank_window_enable;
               s_d.sp = s_q.sp + 4'h1;
            end else begin
               s_d.rsp.io_fault = 1'b1;
            end
            if (cpu_req.op == op_irq_entry) begin
               s_d.bank_window_enable = cpu_req.vec_rbe;
            end
         end
         op_ret, op_irq_ret: begin
            if (s_q.sp != 4'h0) begin
               s_d.bank_window_enable = s_q.stk[s_q.sp[2:0] - 3'h1];
               s_d.sp = s_q.sp - 4'h1;
            end else begin
               s_d.rsp.io_fault = 1'b1;
            end
         end
         // data memory access and peripheral window decode
         op_mem_rd, op_mem_wr: begin
            unique case (cpu_req.mode)
               am_dir_bit, am_dir4: begin
                  addr = {dbank, cpu_req.operand};
                  ok = !s_q.data_bank_enable || (s_q.data_bank_choice == IO_BANK);
               end
               am_dir8: begin
                  addr = {dbank, cpu_req.operand};
                  wide = 1'b1;
                  bad = cpu_req.operand[0];
                  ok = !s_q.data_bank_enable || (s_q.data_bank_choice == IO_BANK);
               end
               am_ind4_hl: begin
                  addr = {(s_q.data_bank_enable ? s_q.data_bank_choice : 4'h0), hv, lv};
                  ok = s_q.data_bank_enable && (s_q.data_bank_choice == IO_BANK);
               end
               am_ind8_hl: begin
                  addr = {(s_q.data_bank_enable ? s_q.data_bank_choice : 4'h0), hv, lv[3:1], 1'b0};
                  wide = 1'b1;
                  ok = s_q.data_bank_enable && (s_q.data_bank_choice == IO_BANK) && !lv[0];
               end
               am_ind_de: addr = {4'h0, dv, ev};
               am_ind_dl: addr = {4'h0, dv, lv};
               am_fmem_bit: begin
                  addr = {IO_BANK, cpu_req.operand};
                  ok = (cpu_req.operand[7:4] == FMEM_IRQ_HI)
                     || (cpu_req.operand[7:4] == FMEM_PORT_HI);
                  bad = !ok;
               end
               am_pmem_bit: begin
                  addr = {IO_BANK, cpu_req.operand[7:2], lv[1:0]};
                  ok = (cpu_req.operand[7:6] == PMEM_HI);
                  bad = !ok;
               end
               default: bad = 1'b1;
            endcase
            inio = (addr >= IO_BASE);
            s_d.rsp.mem_addr = addr;
            s_d.rsp.io_sel = inio && ok && !bad;
            s_d.rsp.io_fault = bad || (inio && !ok);
            if (!bad && (addr < GPR_END)) begin
               // same storage as the register view
               ra = addr[4:0];
               s_d.rsp.reg_hit = 1'b1;
               if (cpu_req.op == op_mem_rd) begin
                  s_d.rsp.rdata = wide ? {s_q.regs[ra | 5'h01], s_q.regs[ra & 5'h1E]}
                     : {4'h0, s_q.regs[ra]};
               end else if (wide) begin
                  s_d.regs[ra & 5'h1E] = cpu_req.wdata[3:0];
                  s_d.regs[ra | 5'h01] = cpu_req.wdata[7:4];
               end else begin
                  s_d.regs[ra] = cpu_req.wdata[3:0];
               end
            end
         end
         default: s_d.rsp.io_fault = 1'b1;
      endcase
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.bank_window_enable <= RST_RBE;
         s_q.data_bank_enable <= RST_MBE;
         s_q.bank_choice_register <= RST_RBS;
         s_q.data_bank_choice <= RST_MBS;
         s_q.wait_q <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

//--- design/gpr_pkg.sv
// Purpose: shared constants and types for the banked register file
// Assumes: one 20 MHz core clock, one asynchronous reset
// Notes: register layout, peripheral window limits and bus offsets
package gpr_pkg;

   // ************************************************************
   // register file geometry
   // ************************************************************
   localparam int unsigned GPR_WORDS = 32;
   localparam logic [2:0] OFF_A = 3'h0;
   localparam logic [2:0] OFF_X = 3'h1;
   localparam logic [2:0] OFF_L = 3'h2;
   localparam logic [2:0] OFF_H = 3'h3;
   localparam logic [2:0] OFF_E = 3'h4;
   localparam logic [2:0] OFF_D = 3'h5;
   localparam logic [2:0] OFF_C = 3'h6;
   localparam logic [2:0] OFF_B = 3'h7;
   localparam logic [11:0] GPR_END = 12'h0020;

   // ************************************************************
   // data memory window limits
   // ************************************************************
   localparam logic [11:0] IO_BASE = 12'h0F80;
   localparam logic [3:0] IO_BANK = 4'hF;
   localparam logic [3:0] FMEM_IRQ_HI = 4'hB;
   localparam logic [3:0] FMEM_PORT_HI = 4'hF;
   localparam logic [1:0] PMEM_HI = 2'h3;
   localparam logic [3:0] RBS_MAX = 4'h3;

   // ************************************************************
   // reset values and save stack
   // ************************************************************
   localparam logic RST_RBE = 1'b0;
   localparam logic RST_MBE = 1'b0;
   localparam logic [3:0] RST_RBS = 4'h0;
   localparam logic [3:0] RST_MBS = 4'h0;
   localparam int unsigned STK_DEPTH = 8;
   localparam logic [3:0] STK_FULL = 4'h8;

   // ************************************************************
   // bus register offsets
   // ************************************************************
   localparam logic [3:0] BUS_STATUS = 4'h0;
   localparam logic [3:0] BUS_INDEX = 4'h4;
   localparam logic [3:0] BUS_DATA = 4'h8;
   localparam logic [3:0] BUS_STACK = 4'hC;

   // ************************************************************
   // request and answer carriers
   // ************************************************************
   typedef enum logic [4:0] {
      op_none, op_rd4, op_wr4, op_xch4, op_rd8, op_wr8, op_add_with_skip_instruction,
      op_set_rbe, op_clr_rbe, op_sel_rb, op_set_mbe, op_clr_mbe, op_sel_mb,
      op_call, op_ret, op_irq_entry, op_irq_ret, op_mem_rd, op_mem_wr,
      op_rd_bs, op_wr_bs
   } gpr_op_t;

   typedef enum logic [3:0] {
      am_dir_bit, am_fmem_bit, am_pmem_bit, am_dir4, am_ind4_hl,
      am_dir8, am_ind8_hl, am_ind_de, am_ind_dl
   } gpr_mode_t;

   typedef struct packed {
      gpr_op_t op;
      gpr_mode_t mode;
      logic [2:0] reg_idx;
      logic alt;
      logic [7:0] operand;
      logic [7:0] wdata;
      logic vec_rbe;
   } gpr_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic skip;
      logic reg_hit;
      logic io_sel;
      logic io_fault;
      logic [11:0] mem_addr;
      logic [1:0] effective_bank;
   } gpr_rsp_t;

endpackage

//--- bench/gpr_bank_asserts.sv
// Purpose: port checks for the banked register file
// Assumes: one clock, sys_rst asynchronous active high
// Notes: bound to every gpr_bank_file below
`timescale 1ns/10ps
module gpr_bank_asserts
   import gpr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // cpu side
   input wire gpr_req_t cpu_req,
   input wire gpr_rsp_t cpu_rsp
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // flag cleared, two idle cycles, then the next operation
   sequence rbe_dropped;
      (cpu_req.op == op_clr_rbe || (cpu_req.op == op_irq_entry && !cpu_req.vec_rbe))
      ##1 (cpu_req.op == op_none && !cpu_rsp.io_fault) ##1 cpu_req.op == op_none
      ##1 cpu_req.op != op_none;
   endsequence
   // combined write, two idle cycles, combined read
   sequence bs_written;
      cpu_req.op == op_wr_bs ##1 cpu_req.op == op_none [*2] ##1 cpu_req.op == op_rd_bs;
   endsequence
   wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus not answered");
   rsp_pulse_a: assert property (cpu_req.op != op_none |=> cpu_rsp.valid)
      else $error("no answer");
   bank_drop_a: assert property (rbe_dropped |=> cpu_rsp.effective_bank == 2'h0)
      else $error("bank not 0");
   bs_pair_a: assert property (bs_written |=> cpu_rsp.rdata ==
      {$past(cpu_req.wdata[7:4], 4), 2'h0, $past(cpu_req.wdata[1:0], 4)})
      else $error("combined state wrong");
   sel_range_a: assert property (
      cpu_req.op == op_sel_rb && cpu_req.operand > {4'h0, RBS_MAX} |=> cpu_rsp.io_fault)
      else $error("bank above 3 taken");
   dir8_odd_a: assert property (cpu_req.op == op_mem_rd && cpu_req.mode == am_dir8
      && cpu_req.operand[0] |=> cpu_rsp.io_fault)
      else $error("odd 8-bit address taken");
   fmem_free_a: assert property (cpu_req.op == op_mem_rd && cpu_req.mode == am_fmem_bit
      && cpu_req.operand[7:4] == FMEM_IRQ_HI |=> cpu_rsp.io_sel && !cpu_rsp.io_fault
      && cpu_rsp.mem_addr == {4'hF, $past(cpu_req.operand)})
      else $error("special bit access refused");
   win_range_a: assert property (cpu_rsp.io_sel |-> cpu_rsp.mem_addr >= IO_BASE)
      else $error("window select outside F80-FFF");
endmodule
bind gpr_bank_file gpr_bank_asserts u_chk (.clock(clock), .sys_rst(sys_rst),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));

//--- bench/gpr_cpu_model.sv
// Purpose: cpu execution side, one operation at a time
// Assumes: each operation is answered by a cpu_rsp.valid pulse
// Notes: idle operand and wdata are scrambled, other request fields held
`timescale 1ns/10ps
module gpr_cpu_model
   import gpr_pkg::*;
(
   // clock
   input wire logic clock,
   // execution port
   output gpr_req_t cpu_req,
   input wire gpr_rsp_t cpu_rsp
);
   initial cpu_req = '0;
   // drive after an edge, go idle after the taking edge, wait for the answer
   task automatic issue(input gpr_req_t r, output gpr_rsp_t rsp, output logic ok);
      gpr_req_t idle;
      int n;
      n = 0;
      idle = r;
      idle.op = op_none;
      idle.operand = ~r.operand;
      idle.wdata = ~r.wdata;
      @(posedge clock);
      cpu_req <= r; // flag by set or clear ops, interrupt entry and return; choice by select or combined write
      do begin
         @(posedge clock);
         if (n == 0) cpu_req <= idle;
         n++;
      end while (cpu_rsp.valid !== 1'b1 && n < 8);
      rsp = cpu_rsp;
      ok = (cpu_rsp.valid === 1'b1);
   endtask
endmodule

//--- bench/testbench.sv
// Purpose: self-checking bench for the banked register file
// Assumes: 50 ns clock, reset held 20 cycles
// Notes: registers over avalon-mm, operations through the cpu model
`timescale 1ns/10ps
module testbench import gpr_pkg::*; ;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic [31:0] rd;
   logic avs_waitrequest;
   logic [7:0] sv;
   gpr_req_t cpu_req;
   gpr_rsp_t cpu_rsp;
   gpr_rsp_t rsp;
   int fail_count = 0;
   int compares = 0;
   // device and cpu model
   gpr_bank_file dut (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));
   gpr_cpu_model u_cpu (.clock(clock), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));
   initial forever #25 clock = ~clock;
   // verdict and end of run
   task automatic complete_run;
      if (fail_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one comparison
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~wr;
      avs_write <= wr;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 16);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         chk(1'b0, "bus timeout");
         complete_run();
      end
   endtask
   // write one nibble register by flat index
   task automatic nib(input int i, input int v);
      bus(1'b1, BUS_INDEX, 32'(i));
      bus(1'b1, BUS_DATA, 32'(v));
   endtask
   // one cpu operation, answer left in rsp
   task automatic cpu(input gpr_op_t op, input gpr_mode_t md = am_dir4,
      input logic [2:0] i = 3'h0, input logic alt = 1'b0, input logic [7:0] opd = 8'h00,
      input logic [7:0] wd = 8'h00, input logic vec = 1'b0);
      gpr_req_t r;
      logic ok;
      r = '{op, md, i, alt, opd, wd, vec};
      u_cpu.issue(r, rsp, ok);
      if (!ok) begin
         chk(1'b0, "cpu timeout");
         complete_run();
      end
   endtask
   // four banks, alternate pairs, forced bank 0, memory alias
   task automatic s_banks;
      bus(1'b0, 4'h2, 32'h0000_0000);
      chk(rd === 32'h0000_0000, "unmapped read");
      for (int b = 0; b < 4; b++) begin
         nib(b * 8 + OFF_A, b + 1);
         nib(b * 8 + OFF_X, b + 8);
      end
      cpu(op_set_rbe);
      for (int b = 0; b < 4; b++) begin
         cpu(op_sel_rb, am_dir4, 3'h0, 1'b0, 8'(b));
         cpu(op_rd8);
         chk(rsp.rdata === 8'((b + 8) * 16 + b + 1) && rsp.effective_bank === 2'(b), "pair");
         cpu(op_rd8, am_dir4, 3'h0, 1'b1);
         chk(rsp.rdata === 8'(((b ^ 1) + 8) * 16 + (b ^ 1) + 1), "alternate");
      end
      cpu(op_clr_rbe);
      cpu(op_rd8);
      chk(rsp.rdata === 8'h81 && rsp.effective_bank === 2'h0, "flag clear");
      cpu(op_mem_rd, am_dir4, 3'h0, 1'b0, 8'h18);
      chk(rsp.reg_hit === 1'b1 && rsp.rdata[3:0] === 4'h4, "alias");
   endtask
   // add with skip on bank 0 pairs
   task automatic s_add_with_skip_instruction;
      nib(OFF_A, 0);
      nib(OFF_X, 15);
      nib(OFF_C, 0);
      nib(OFF_B, 2);
      cpu(op_add_with_skip_instruction, am_dir4, 3'h6);
      chk(rsp.rdata === 8'h10 && rsp.skip === 1'b1, "carry");
      cpu(op_add_with_skip_instruction, am_dir4, 3'h6);
      chk(rsp.rdata === 8'h30 && rsp.skip === 1'b0, "no carry");
      cpu(op_rd8);
      chk(rsp.rdata === 8'h30, "accumulator");
      cpu(op_wr4, am_dir4, 3'h7, 1'b0, 8'h00, 8'h09);
      cpu(op_xch4, am_dir4, 3'h7);
      chk(rsp.rdata === 8'h09, "exchange");
      cpu(op_rd4);
      chk(rsp.rdata === 8'h09, "accumulator nibble");
      cpu(op_mem_wr, am_dir4, 3'h0, 1'b0, 8'h07, 8'h05);
      cpu(op_rd4, am_dir4, 3'h7);
      chk(rsp.rdata === 8'h05, "memory write alias");
   endtask
   // flag save on call and interrupt, choice kept by software
   task automatic s_save;
      cpu(op_set_rbe);
      cpu(op_call);
      cpu(op_clr_rbe);
      cpu(op_ret);
      bus(1'b0, BUS_STATUS, 32'h0000_0000);
      chk(rd[2] === 1'b1, "return");
      cpu(op_irq_entry);
      bus(1'b0, BUS_STATUS, 32'h0000_0000);
      chk(rd[2] === 1'b0, "vector flag");
      cpu(op_rd_bs);
      sv = rsp.rdata;
      cpu(op_sel_rb, am_dir4, 3'h0, 1'b0, 8'h01);
      cpu(op_wr_bs, am_dir4, 3'h0, 1'b0, 8'h00, sv);
      cpu(op_irq_ret);
      bus(1'b0, BUS_STATUS, 32'h0000_0000);
      chk(rd[2] === 1'b1 && rd[7:4] === 4'h3, "interrupt return");
      cpu(op_wr_bs, am_dir4, 3'h0, 1'b0, 8'h00, 8'hF2);
      cpu(op_rd_bs);
      chk(rsp.rdata === 8'hF2, "combined");
      bus(1'b0, BUS_STATUS, 32'h0000_0000);
      chk(rd[11:0] === 12'hF26, "status");
   endtask
   // peripheral window conditions per mode
   task automatic s_window;
      cpu(op_sel_rb, am_dir4, 3'h0, 1'b0, 8'h04);
      chk(rsp.io_fault === 1'b1, "bank 4");
      cpu(op_mem_rd, am_dir4, 3'h0, 1'b0, 8'h85);
      chk(rsp.io_sel === 1'b1 && rsp.mem_addr === 12'hF85, "direct");
      cpu(op_mem_rd, am_fmem_bit, 3'h0, 1'b0, 8'hB3);
      chk(rsp.io_sel === 1'b1 && rsp.mem_addr === 12'hFB3, "special bit");
      cpu(op_mem_rd, am_dir8, 3'h0, 1'b0, 8'h87);
      chk(rsp.io_fault === 1'b1, "odd");
      cpu(op_wr8, am_dir4, 3'h2, 1'b0, 8'h00, 8'h86);
      cpu(op_mem_rd, am_ind4_hl);
      chk(rsp.io_sel === 1'b0 && rsp.mem_addr === 12'h086, "pointer");
      cpu(op_set_mbe);
      cpu(op_mem_rd, am_ind8_hl);
      chk(rsp.io_sel === 1'b1 && rsp.mem_addr === 12'hF86, "pointer 15");
      cpu(op_sel_mb, am_dir4, 3'h0, 1'b0, 8'h00);
      cpu(op_mem_rd, am_dir_bit, 3'h0, 1'b0, 8'h85);
      chk(rsp.io_sel === 1'b0 && rsp.mem_addr === 12'h085, "bit bank 0");
      cpu(op_sel_mb, am_dir4, 3'h0, 1'b0, 8'h0F);
      cpu(op_wr8, am_dir4, 3'h4, 1'b0, 8'h00, 8'h05);
      cpu(op_mem_rd, am_ind_de);
      chk(rsp.reg_hit === 1'b1 && rsp.mem_addr === 12'h005, "aux pointer");
      cpu(op_mem_rd, am_ind_dl);
      chk(rsp.reg_hit === 1'b1 && rsp.mem_addr === 12'h006, "aux low pointer");
      cpu(op_mem_rd, am_pmem_bit, 3'h0, 1'b0, 8'hC0);
      chk(rsp.io_sel === 1'b1 && rsp.mem_addr === 12'hFC2, "bit indirect");
   endtask
   // reset, scenarios, verdict
   initial begin
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      s_banks();
      s_add_with_skip_instruction();
      s_save();
      s_window();
      complete_run();
   end
endmodule
